// file: core/thermal_fan_pkg.sv
// Shared constants of the thermal fan register bank
package thermal_fan_pkg;
  localparam int DATA_W = 8;
  localparam int IDX_W = 5;
  localparam int LUT_IDX_W = 5;
  localparam int LUT_DEPTH = 24;
  localparam int NUM_STORE = 22;
  // --------------------------------------------------------------
  // Byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] OFS_RT_SIGNED_HIGH = 8'h01;
  localparam logic [7:0] OFS_ALARM_STATUS = 8'h02;
  localparam logic [7:0] OFS_MAIN_CFG = 8'h03;
  localparam logic [7:0] OFS_CONV_RATE = 8'h04;
  localparam logic [7:0] OFS_LOCAL_HIGH = 8'h05;
  localparam logic [7:0] OFS_GAP_LOW = 8'h06;
  localparam logic [7:0] OFS_RHIGH_MSB = 8'h07;
  localparam logic [7:0] OFS_RLOW_MSB = 8'h08;
  localparam logic [7:0] OFS_MAIN_CFG_MIRROR = 8'h09;
  localparam logic [7:0] OFS_CONV_RATE_MIRROR = 8'h0a;
  localparam logic [7:0] OFS_LOCAL_HIGH_MIRROR = 8'h0b;
  localparam logic [7:0] OFS_GAP_HIGH = 8'h0c;
  localparam logic [7:0] OFS_RHIGH_MSB_MIRROR = 8'h0d;
  localparam logic [7:0] OFS_RLOW_MSB_MIRROR = 8'h0e;
  localparam logic [7:0] OFS_ONE_SHOT = 8'h0f;
  localparam logic [7:0] OFS_RT_SIGNED_LOW = 8'h10;
  localparam logic [7:0] OFS_ROFF_MSB = 8'h11;
  localparam logic [7:0] OFS_ROFF_LSB = 8'h12;
  localparam logic [7:0] OFS_RHIGH_LSB = 8'h13;
  localparam logic [7:0] OFS_RLOW_LSB = 8'h14;
  localparam logic [7:0] OFS_ALARM_MASK = 8'h16;
  localparam logic [7:0] OFS_CRIT_LIMIT = 8'h19;
  localparam logic [7:0] OFS_CRIT_HYST = 8'h21;
  localparam logic [7:0] OFS_RT_UNSIGNED_HIGH = 8'h31;
  localparam logic [7:0] OFS_RT_UNSIGNED_LOW = 8'h32;
  localparam logic [7:0] OFS_POWER_ON_STATUS = 8'h33;
  localparam logic [7:0] OFS_ENH_CFG = 8'h45;
  localparam logic [7:0] OFS_PCOUNT_LOW = 8'h46;
  localparam logic [7:0] OFS_PCOUNT_HIGH = 8'h47;
  localparam logic [7:0] OFS_PLIM_LOW = 8'h48;
  localparam logic [7:0] OFS_PLIM_HIGH = 8'h49;
  localparam logic [7:0] OFS_DUTY_SPEED = 8'h4a;
  localparam logic [7:0] OFS_STARTUP = 8'h4b;
  localparam logic [7:0] OFS_DUTY_VALUE = 8'h4c;
  localparam logic [7:0] OFS_DUTY_FREQ = 8'h4d;
  localparam logic [7:0] OFS_TABLE_OFS = 8'h4e;
  localparam logic [7:0] OFS_TABLE_HYST = 8'h4f;
  localparam logic [7:0] OFS_LUT_BASE = 8'h50;
  localparam logic [7:0] OFS_LUT_LAST = 8'h67;
  localparam logic [7:0] OFS_FILTER = 8'hbf;
  localparam logic [7:0] OFS_MAKER_ID = 8'hfe;
  localparam logic [7:0] OFS_DIE_REV_ID = 8'hff;
  // --------------------------------------------------------------
  // Storage slots of the writable registers
  // --------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_MAIN_CFG = 5'h00;
  localparam logic [IDX_W-1:0] IDX_CONV_RATE = 5'h01;
  localparam logic [IDX_W-1:0] IDX_LOCAL_HIGH = 5'h02;
  localparam logic [IDX_W-1:0] IDX_RHIGH_MSB = 5'h03;
  localparam logic [IDX_W-1:0] IDX_RLOW_MSB = 5'h04;
  localparam logic [IDX_W-1:0] IDX_ROFF_MSB = 5'h05;
  localparam logic [IDX_W-1:0] IDX_ROFF_LSB = 5'h06;
  localparam logic [IDX_W-1:0] IDX_RHIGH_LSB = 5'h07;
  localparam logic [IDX_W-1:0] IDX_RLOW_LSB = 5'h08;
  localparam logic [IDX_W-1:0] IDX_ALARM_MASK = 5'h09;
  localparam logic [IDX_W-1:0] IDX_CRIT_LIMIT = 5'h0a;
  localparam logic [IDX_W-1:0] IDX_CRIT_HYST = 5'h0b;
  localparam logic [IDX_W-1:0] IDX_ENH_CFG = 5'h0c;
  localparam logic [IDX_W-1:0] IDX_PLIM_LOW = 5'h0d;
  localparam logic [IDX_W-1:0] IDX_PLIM_HIGH = 5'h0e;
  localparam logic [IDX_W-1:0] IDX_DUTY_SPEED = 5'h0f;
  localparam logic [IDX_W-1:0] IDX_STARTUP = 5'h10;
  localparam logic [IDX_W-1:0] IDX_DUTY_VALUE = 5'h11;
  localparam logic [IDX_W-1:0] IDX_DUTY_FREQ = 5'h12;
  localparam logic [IDX_W-1:0] IDX_TABLE_OFS = 5'h13;
  localparam logic [IDX_W-1:0] IDX_TABLE_HYST = 5'h14;
  localparam logic [IDX_W-1:0] IDX_FILTER = 5'h15;
  // Reset values and writable-bit masks, slot 21 first
  localparam logic [NUM_STORE-1:0][7:0] STORE_RESET = {
    8'h00, 8'h04, 8'h00, 8'h17, 8'h00, 8'h3f, 8'h20, 8'hff, 8'hff, 8'h00, 8'h0a,
    8'h6e, 8'ha4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h69, 8'h46, 8'h08, 8'h00};
  localparam logic [NUM_STORE-1:0][7:0] STORE_WMASK = {
    8'h07, 8'h1f, 8'h3f, 8'h1f, 8'hff, 8'h3f, 8'h3b, 8'hff, 8'hfc, 8'h7f, 8'hff,
    8'hff, 8'h5b, 8'he0, 8'he0, 8'he0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] LUT_RST_TEMP = 8'h7f;
  localparam logic [7:0] LUT_RST_DUTY = 8'h3f;
  localparam int UNLOCK_BIT = 5;
  localparam int NOT_READY_BIT = 7;

  // Merge a host byte into a slot, keeping unused bits
  function automatic logic [7:0] merge_byte(logic [7:0] old, logic [7:0] wdata,
                                            logic [7:0] mask);
    merge_byte = (old & ~mask) | (wdata & mask);
  endfunction : merge_byte
endpackage : thermal_fan_pkg

// file: core/reg_decode.sv
// Address decoder of the thermal fan register bank
`timescale 1ns/1ps
module reg_decode
  import thermal_fan_pkg::*;
(
  input wire logic [7:0] addr,
  output logic store_hit,
  output logic [IDX_W-1:0] store_idx,
  output logic lut_hit,
  output logic [LUT_IDX_W-1:0] lut_idx,
  output logic fan_gated
);
  logic [7:0] lut_off;

  // Map each address, mirrors included, onto its slot
  always_comb
  begin
    store_hit = 1'b1;
    store_idx = IDX_MAIN_CFG;
    lut_hit = 1'b0;
    fan_gated = 1'b0;
    lut_off = addr - OFS_LUT_BASE;
    lut_idx = lut_off[LUT_IDX_W-1:0];
    case (addr)
      OFS_MAIN_CFG, OFS_MAIN_CFG_MIRROR: store_idx = IDX_MAIN_CFG;
      OFS_CONV_RATE, OFS_CONV_RATE_MIRROR: store_idx = IDX_CONV_RATE;
      OFS_LOCAL_HIGH, OFS_LOCAL_HIGH_MIRROR: store_idx = IDX_LOCAL_HIGH;
      OFS_RHIGH_MSB, OFS_RHIGH_MSB_MIRROR: store_idx = IDX_RHIGH_MSB;
      OFS_RLOW_MSB, OFS_RLOW_MSB_MIRROR: store_idx = IDX_RLOW_MSB;
      OFS_ROFF_MSB: store_idx = IDX_ROFF_MSB;
      OFS_ROFF_LSB: store_idx = IDX_ROFF_LSB;
      OFS_RHIGH_LSB: store_idx = IDX_RHIGH_LSB;
      OFS_RLOW_LSB: store_idx = IDX_RLOW_LSB;
      OFS_ALARM_MASK: store_idx = IDX_ALARM_MASK;
      OFS_CRIT_LIMIT: store_idx = IDX_CRIT_LIMIT;
      OFS_CRIT_HYST: store_idx = IDX_CRIT_HYST;
      OFS_PLIM_LOW: store_idx = IDX_PLIM_LOW;
      OFS_PLIM_HIGH: store_idx = IDX_PLIM_HIGH;
      OFS_DUTY_SPEED: store_idx = IDX_DUTY_SPEED;
      OFS_FILTER: store_idx = IDX_FILTER;
      OFS_ENH_CFG:
      begin
        store_idx = IDX_ENH_CFG;
        fan_gated = 1'b1;
      end
      OFS_STARTUP:
      begin
        store_idx = IDX_STARTUP;
        fan_gated = 1'b1;
      end
      OFS_DUTY_VALUE:
      begin
        store_idx = IDX_DUTY_VALUE;
        fan_gated = 1'b1;
      end
      OFS_DUTY_FREQ:
      begin
        store_idx = IDX_DUTY_FREQ;
        fan_gated = 1'b1;
      end
      OFS_TABLE_OFS:
      begin
        store_idx = IDX_TABLE_OFS;
        fan_gated = 1'b1;
      end
      OFS_TABLE_HYST:
      begin
        store_idx = IDX_TABLE_HYST;
        fan_gated = 1'b1;
      end
      default:
      begin
        // Gaps and read-only locations own no slot
        store_hit = 1'b0;
        if (addr >= OFS_LUT_BASE && addr <= OFS_LUT_LAST)
        begin
          lut_hit = 1'b1;
          fan_gated = 1'b1;
        end
      end
    endcase
  end
endmodule : reg_decode

// file: core/fan_table_store.sv
// Flip-flop storage of the fan lookup table
`timescale 1ns/1ps
module fan_table_store
  import thermal_fan_pkg::*;
#(
  parameter int DEPTH = LUT_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [LUT_IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [LUT_IDX_W-1:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic [LUT_IDX_W-1:0] fan_idx,
  output logic [7:0] fan_data
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] entry;
  } table_state_t;

  table_state_t st;
  table_state_t next_st;

  // Even entries hold temperatures, odd entries duty cycles
  always_comb
  begin
    next_st = st;
    if (wr_en && wr_idx < DEPTH[LUT_IDX_W-1:0])
      next_st.entry[wr_idx] = wr_data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        st.entry[i] <= (i % 2 == 0) ? LUT_RST_TEMP : LUT_RST_DUTY;
    end
    else
      st <= next_st;
  end

  // Two read ports, host side and fan logic side
  assign rd_data = (rd_idx < DEPTH[LUT_IDX_W-1:0]) ? st.entry[rd_idx] : 8'h00;
  assign fan_data = (fan_idx < DEPTH[LUT_IDX_W-1:0]) ? st.entry[fan_idx] : 8'h00;
endmodule : fan_table_store

// file: core/thermal_fan_bank.sv
// Register bank of the remote-diode thermal sensor with fan control
// Operation
// - Each mirror address pair shares one 8-bit register for reads and writes.
// - Duty cycle value is read-only unless the fan write unlock bit is set.
// - Writes to 0x45, 0x4b-0x4f and the table land only while unlock is 1; host clears after table.
// - Compatibility gaps and other unused addresses hold no function.
`timescale 1ns/1ps
module thermal_fan_bank
  import thermal_fan_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a,   // arbitrary value
  parameter logic [7:0] DIE_REV_ID = 8'h3c  // arbitrary value
)
(
  input wire logic mclk,
  input wire logic rst_n,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Values measured elsewhere in the device
  input wire logic [7:0] local_temperature,
  input wire logic [7:0] remote_temp_signed_high,
  input wire logic [7:0] remote_temp_signed_low,
  input wire logic [7:0] remote_temp_unsigned_high,
  input wire logic [7:0] remote_temp_unsigned_low,
  input wire logic [7:0] alarm_status,
  input wire logic [7:0] fan_pulse_count_low,
  input wire logic [7:0] fan_pulse_count_high,
  input wire logic not_ready,
  // Settings towards the device logic
  output logic [7:0] main_configuration,
  output logic [7:0] conversion_rate,
  output logic [7:0] local_high_limit,
  output logic [7:0] remote_high_limit_msb,
  output logic [7:0] remote_low_limit_msb,
  output logic [7:0] remote_offset_msb,
  output logic [7:0] remote_offset_lsb,
  output logic [7:0] remote_high_limit_lsb,
  output logic [7:0] remote_low_limit_lsb,
  output logic [7:0] alarm_mask,
  output logic [7:0] remote_critical_limit,
  output logic [7:0] remote_critical_hysteresis,
  output logic [7:0] enhanced_configuration,
  output logic [7:0] fan_pulse_limit_low,
  output logic [7:0] fan_pulse_limit_high,
  output logic [7:0] duty_speed_configuration,
  output logic [7:0] fan_startup_configuration,
  output logic [7:0] duty_cycle_value,
  output logic [7:0] duty_cycle_frequency,
  output logic [7:0] table_temp_offset,
  output logic [7:0] table_hysteresis,
  output logic [7:0] remote_filter_comparator,
  output logic fan_reg_write_unlock,
  output logic single_conversion_trigger,
  // Lookup table read port for the fan logic
  input wire logic [LUT_IDX_W-1:0] fan_table_index,
  output logic [7:0] fan_table_data
);
  // ------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_STORE-1:0][7:0] store;
    logic [7:0] rdata;
    logic rvalid;
    logic trigger;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;
  logic store_hit;
  logic [IDX_W-1:0] store_idx;
  logic lut_hit;
  logic [LUT_IDX_W-1:0] lut_idx;
  logic fan_gated;
  logic write_ok;
  logic lut_write;
  logic [7:0] lut_rdata;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Address to slot mapping
  reg_decode u_decode (
    .addr(reg_addr),
    .store_hit(store_hit),
    .store_idx(store_idx),
    .lut_hit(lut_hit),
    .lut_idx(lut_idx),
    .fan_gated(fan_gated)
  );

  // Gated fan registers need the unlock bit
  assign fan_reg_write_unlock = st.store[IDX_DUTY_SPEED][UNLOCK_BIT];
  assign write_ok = reg_write && (!fan_gated || fan_reg_write_unlock);
  assign lut_write = write_ok && lut_hit;

  // Lookup table entries
  fan_table_store #(
    .DEPTH(LUT_DEPTH)
  ) u_table (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(lut_write),
    .wr_idx(lut_idx),
    .wr_data(reg_wdata),
    .rd_idx(lut_idx),
    .rd_data(lut_rdata),
    .fan_idx(fan_table_index),
    .fan_data(fan_table_data)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rvalid = reg_read;
    next_st.trigger = reg_write && reg_addr == OFS_ONE_SHOT;
    // Stored slot write; table writes go to u_table, all else is dropped
    if (write_ok && store_hit)
      next_st.store[store_idx] = merge_byte(st.store[store_idx], reg_wdata,
                                            STORE_WMASK[store_idx]);
    // Read data; reads see the value before a same-cycle write
    if (reg_read)
    begin
      if (store_hit)
        next_st.rdata = st.store[store_idx];
      else if (lut_hit)
        next_st.rdata = lut_rdata;
      else
      begin
        case (reg_addr)
          OFS_LOCAL_TEMP: next_st.rdata = local_temperature;
          OFS_RT_SIGNED_HIGH: next_st.rdata = remote_temp_signed_high;
          OFS_RT_SIGNED_LOW: next_st.rdata = remote_temp_signed_low;
          OFS_RT_UNSIGNED_HIGH: next_st.rdata = remote_temp_unsigned_high;
          OFS_RT_UNSIGNED_LOW: next_st.rdata = remote_temp_unsigned_low;
          OFS_ALARM_STATUS: next_st.rdata = alarm_status;
          OFS_PCOUNT_LOW: next_st.rdata = fan_pulse_count_low;
          OFS_PCOUNT_HIGH: next_st.rdata = fan_pulse_count_high;
          OFS_POWER_ON_STATUS: next_st.rdata = {not_ready, 7'h00};
          OFS_MAKER_ID: next_st.rdata = MAKER_ID;
          OFS_DIE_REV_ID: next_st.rdata = DIE_REV_ID;
          default: next_st.rdata = 8'h00;
        endcase
      end
    end
  end

  // Register the whole state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.store <= STORE_RESET;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
      st.trigger <= 1'b0;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign single_conversion_trigger = st.trigger;
  assign main_configuration = st.store[IDX_MAIN_CFG];
  assign conversion_rate = st.store[IDX_CONV_RATE];
  assign local_high_limit = st.store[IDX_LOCAL_HIGH];
  assign remote_high_limit_msb = st.store[IDX_RHIGH_MSB];
  assign remote_low_limit_msb = st.store[IDX_RLOW_MSB];
  assign remote_offset_msb = st.store[IDX_ROFF_MSB];
  assign remote_offset_lsb = st.store[IDX_ROFF_LSB];
  assign remote_high_limit_lsb = st.store[IDX_RHIGH_LSB];
  assign remote_low_limit_lsb = st.store[IDX_RLOW_LSB];
  assign alarm_mask = st.store[IDX_ALARM_MASK];
  assign remote_critical_limit = st.store[IDX_CRIT_LIMIT];
  assign remote_critical_hysteresis = st.store[IDX_CRIT_HYST];
  assign enhanced_configuration = st.store[IDX_ENH_CFG];
  assign fan_pulse_limit_low = st.store[IDX_PLIM_LOW];
  assign fan_pulse_limit_high = st.store[IDX_PLIM_HIGH];
  assign duty_speed_configuration = st.store[IDX_DUTY_SPEED];
  assign fan_startup_configuration = st.store[IDX_STARTUP];
  assign duty_cycle_value = st.store[IDX_DUTY_VALUE];
  assign duty_cycle_frequency = st.store[IDX_DUTY_FREQ];
  assign table_temp_offset = st.store[IDX_TABLE_OFS];
  assign table_hysteresis = st.store[IDX_TABLE_HYST];
  assign remote_filter_comparator = st.store[IDX_FILTER];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Write at one mirror, read back at the other
  sequence mirror_write_s;
    reg_write && reg_addr == OFS_MAIN_CFG_MIRROR;
  endsequence
  sequence mirror_read_s;
    reg_read && !reg_write && reg_addr == OFS_MAIN_CFG;
  endsequence
  AST_MIRROR_SHARED: assert property (
    mirror_write_s ##1 !reg_write ##1 mirror_read_s |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mirror address did not share storage");

  AST_MIRROR_RATE: assert property (
    reg_write && reg_addr == OFS_CONV_RATE_MIRROR |=>
      conversion_rate == $past(reg_wdata))
    else $error("rate mirror write lost");

  // Duty value locked without unlock
  AST_DUTY_LOCKED: assert property (
    reg_write && reg_addr == OFS_DUTY_VALUE && !fan_reg_write_unlock |=>
      $stable(duty_cycle_value))
    else $error("duty value changed while locked");

  AST_DUTY_OPEN: assert property (
    reg_write && reg_addr == OFS_DUTY_VALUE && fan_reg_write_unlock |=>
      duty_cycle_value == $past(reg_wdata))
    else $error("duty value not written while unlocked");

  // Other fan registers also locked
  AST_FAN_LOCKED: assert property (
    reg_write && fan_gated && !fan_reg_write_unlock |=>
      $stable(st.store) && $stable(fan_table_data))
    else $error("fan register changed while locked");

  // Unlock bit follows the written value
  AST_UNLOCK_TRACK: assert property (
    reg_write && reg_addr == OFS_DUTY_SPEED |=>
      fan_reg_write_unlock == $past(reg_wdata[UNLOCK_BIT]))
    else $error("unlock bit did not follow write");

  // Gaps read zero and ignore writes
  AST_GAP_READ: assert property (
    reg_read && (reg_addr == OFS_GAP_LOW || reg_addr == OFS_GAP_HIGH) |=>
      reg_rvalid && reg_rdata == 8'h00)
    else $error("gap address read not zero");

  AST_IGNORED_WRITE: assert property (
    reg_write && !store_hit && !lut_hit |=> $stable(st.store))
    else $error("ignored write changed a register");

  // Power-on status reflects not-ready
  AST_POWER_STATUS: assert property (
    reg_read && reg_addr == OFS_POWER_ON_STATUS |=>
      reg_rdata[NOT_READY_BIT] == $past(not_ready) && reg_rdata[6:0] == 7'h00)
    else $error("power-on status read wrong");

  // Trigger write gives a one-cycle pulse
  sequence trigger_pulse_s;
    single_conversion_trigger ##1 !single_conversion_trigger;
  endsequence
  AST_TRIGGER_PULSE: assert property (
    reg_write && reg_addr == OFS_ONE_SHOT ##1 !(reg_write && reg_addr == OFS_ONE_SHOT)
      |-> trigger_pulse_s)
    else $error("trigger pulse malformed");
endmodule : thermal_fan_bank

// file: bench/host_firmware.sv
// Host firmware model driving the register port of the bank
`timescale 1ns/1ps
module host_firmware
  import thermal_fan_pkg::*;
(
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // One write strobe; data goes to its inverse once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge mclk);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // One read strobe; answer taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge mclk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge mclk);
    reg_read = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd

  // Start-up order of the fan registers, table or direct duty
  task automatic fan_setup(input logic use_table, output logic ready);
    logic [7:0] d;
    logic ok;
    ready = 1'b0;
    for (int n = 0; n < 50 && !ready; n++)
    begin
      rd(OFS_POWER_ON_STATUS, d, ok);
      ready = ok && !d[NOT_READY_BIT];
    end
    // No fan register is touched before the device is ready
    if (ready)
    begin
      wr(OFS_DUTY_SPEED, 8'h3b);
      wr(OFS_STARTUP, 8'h25);
      wr(OFS_DUTY_FREQ, 8'h11);
      wr(OFS_ENH_CFG, 8'h10);
      if (use_table)
      begin
        wr(OFS_LUT_BASE, 8'h35);
        wr(OFS_TABLE_OFS, 8'h2a);
        wr(OFS_DUTY_SPEED, 8'h1b);
      end
      else
        wr(OFS_DUTY_VALUE, 8'h2c);
    end
  endtask : fan_setup
endmodule : host_firmware

// file: bench/test_thermal_fan_bank.sv
// Self-checking bench of the thermal fan register bank
`timescale 1ns/1ps
`define CHK(got, e) begin total_checks++; if ((got) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (e)); end end
module test_thermal_fan_bank
  import thermal_fan_pkg::*;
;
  localparam logic [7:0] ID_A = 8'h6b; // arbitrary value
  localparam logic [7:0] ID_B = 8'h2d; // arbitrary value
  int n_mismatch = 0;
  int total_checks = 0;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic not_ready = 1'b1;
  logic [7:0] meas [8];
  logic [LUT_IDX_W-1:0] fan_table_index = '0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fan_table_data, duty_cycle_value;
  logic [7:0] duty_speed_configuration, main_configuration;
  logic [7:0] fan_startup_configuration, duty_cycle_frequency, enhanced_configuration;
  logic [7:0] table_temp_offset;
  logic reg_write, reg_read, reg_rvalid, fan_reg_write_unlock, single_conversion_trigger;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  thermal_fan_bank #(.MAKER_ID(ID_A), .DIE_REV_ID(ID_B)) i_thermal_fan_bank (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .local_temperature(meas[0]), .remote_temp_signed_high(meas[1]),
    .remote_temp_signed_low(meas[2]), .remote_temp_unsigned_high(meas[3]),
    .remote_temp_unsigned_low(meas[4]), .alarm_status(meas[5]),
    .fan_pulse_count_low(meas[6]), .fan_pulse_count_high(meas[7]), .not_ready(not_ready),
    .main_configuration(main_configuration), .conversion_rate(), .local_high_limit(),
    .remote_high_limit_msb(), .remote_low_limit_msb(), .remote_offset_msb(),
    .remote_offset_lsb(), .remote_high_limit_lsb(), .remote_low_limit_lsb(), .alarm_mask(),
    .remote_critical_limit(), .remote_critical_hysteresis(),
    .enhanced_configuration(enhanced_configuration),
    .fan_pulse_limit_low(), .fan_pulse_limit_high(),
    .duty_speed_configuration(duty_speed_configuration),
    .fan_startup_configuration(fan_startup_configuration),
    .duty_cycle_value(duty_cycle_value), .duty_cycle_frequency(duty_cycle_frequency),
    .table_temp_offset(table_temp_offset),
    .table_hysteresis(), .remote_filter_comparator(),
    .fan_reg_write_unlock(fan_reg_write_unlock),
    .single_conversion_trigger(single_conversion_trigger),
    .fan_table_index(fan_table_index), .fan_table_data(fan_table_data));

  host_firmware i_host_firmware (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Read one address and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_host_firmware.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask : rchk

  // Reset values of the register table
  task automatic t_reset();
    logic [15:0] t [25] = '{16'h0300, 16'h0408, 16'h0546, 16'h0769, 16'h0800, 16'h1100,
      16'h1200, 16'h1300, 16'h1400, 16'h16a4, 16'h196e, 16'h210a, 16'h4500, 16'h48ff,
      16'h49ff, 16'h4a20, 16'h4b3f, 16'h4c00, 16'h4d17, 16'h4e00, 16'h4f04, 16'hbf00,
      16'h507f, {8'hfe, ID_A}, {8'hff, ID_B}};
    for (int i = 0; i < 25; i++)
      rchk(t[i][15:8], t[i][7:0]);
    `CHK(fan_reg_write_unlock, 1'b1)
    `CHK(fan_table_data, 8'h7f)
    fan_table_index = 5'h01;
    @(negedge mclk);
    `CHK(fan_table_data, 8'h3f)
    fan_table_index = 5'h00;
  endtask : t_reset

  // Measured values pass through reads
  task automatic t_inputs();
    logic [7:0] a [8] = '{8'h00, 8'h01, 8'h10, 8'h31, 8'h32, 8'h02, 8'h46, 8'h47};
    for (int i = 0; i < 8; i++)
      rchk(a[i], meas[i]);
    rchk(8'h33, 8'h80);
  endtask : t_inputs

  // Table set-up after not-ready clears, then lock holds
  task automatic t_setup();
    logic ok;
    fork
      i_host_firmware.fan_setup(1'b1, ok);
      begin
        repeat (12) @(negedge mclk);
        `CHK(duty_speed_configuration, 8'h20)
        not_ready = 1'b0;
      end
    join
    `CHK(ok, 1'b1)
    `CHK(fan_reg_write_unlock, 1'b0)
    `CHK(fan_table_data, 8'h35)
    `CHK(fan_startup_configuration, 8'h25)
    `CHK(duty_cycle_frequency, 8'h11)
    `CHK(enhanced_configuration, 8'h10)
    `CHK(table_temp_offset, 8'h2a)
    rchk(8'h4a, 8'h1b);
    rchk(8'h4b, 8'h25);
    rchk(8'h4d, 8'h11);
    rchk(8'h45, 8'h10);
    rchk(8'h4e, 8'h2a);
    i_host_firmware.wr(8'h4c, 8'h3f);
    i_host_firmware.wr(8'h4b, 8'h00);
    i_host_firmware.wr(8'h50, 8'h11);
    rchk(8'h4c, 8'h00);
    rchk(8'h4b, 8'h25);
    rchk(8'h50, 8'h35);
  endtask : t_setup

  // Direct duty option with unlock set
  task automatic t_option_b();
    logic ok;
    i_host_firmware.fan_setup(1'b0, ok);
    `CHK(ok, 1'b1)
    `CHK(fan_reg_write_unlock, 1'b1)
    `CHK(duty_cycle_value, 8'h2c)
    rchk(8'h4c, 8'h2c);
  endtask : t_option_b

  // Mirror pairs share one register
  task automatic t_mirror();
    logic [23:0] t [4] = '{24'h09035a, 24'h0a0407, 24'h0d0755, 24'h050b33};
    for (int i = 0; i < 4; i++)
    begin
      i_host_firmware.wr(t[i][23:16], t[i][7:0]);
      rchk(t[i][15:8], t[i][7:0]);
    end
    `CHK(main_configuration, 8'h5a)
  endtask : t_mirror

  // Unused and read-only places ignore writes
  task automatic t_unused();
    logic [7:0] a [6] = '{8'h06, 8'h0c, 8'h15, 8'h6a, 8'hc0, 8'h33};
    for (int i = 0; i < 6; i++)
      i_host_firmware.wr(a[i], 8'hff);
    i_host_firmware.wr(8'h00, 8'hff);
    for (int i = 0; i < 6; i++)
      rchk(a[i], 8'h00);
    rchk(8'h00, meas[0]);
    rchk(8'h03, 8'h5a);
  endtask : t_unused

  // Single conversion pulse lasts one cycle
  task automatic t_trigger();
    i_host_firmware.wr(8'h0f, 8'h01);
    `CHK(single_conversion_trigger, 1'b1)
    @(negedge mclk);
    `CHK(single_conversion_trigger, 1'b0)
    rchk(8'h0f, 8'h00);
  endtask : t_trigger

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    for (int i = 0; i < 8; i++)
      meas[i] = {4'(i), 4'ha};
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_inputs();
    t_setup();
    t_option_b();
    t_mirror();
    t_unused();
    t_trigger();
    report_and_stop();
  end

  // Watchdog against a hang
  initial
  begin
    #50us;
    n_mismatch++;
    report_and_stop();
  end
endmodule : test_thermal_fan_bank
